/* core/lf_clock_pkg.sv */
// Constants for the low-frequency clock gate and prescaler bank.
// Assumes a 32-bit APB register bus on ref_clk.
`default_nettype none
package lf_clock_pkg;
  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] off_freeze = 8'h54;
  localparam logic [7:0] off_lfa_gates = 8'h58;
  localparam logic [7:0] off_lfb_gates = 8'h60;
  localparam logic [7:0] off_lfa_presc = 8'h68;
  localparam logic [7:0] off_lfb_presc = 8'h70;
  localparam logic [7:0] off_pcnt_ctrl = 8'h78;
  localparam logic [7:0] off_disp_ctrl = 8'h7c;
  localparam logic [7:0] off_route = 8'h80;
  localparam logic [7:0] off_lock = 8'h84;
  localparam logic [7:0] off_sync_busy = 8'h50;
  // ------------------------------------------------------------
  // Fields, keys and reset values
  // ------------------------------------------------------------
  localparam logic [15:0] unlock_key = 16'h580e;
  localparam logic [2:0] boost_div_reset = 3'h2;
  localparam int busy_lfa_gates_bit = 0;
  localparam int busy_lfa_presc_bit = 2;
  localparam int busy_lfb_gates_bit = 4;
  localparam int busy_lfb_presc_bit = 6;
  localparam int disp_presc_base = 4;
  // Number of async registers crossing into the low-frequency side
  localparam int num_async = 4;
endpackage
`default_nettype wire

/* core/lf_divider.sv */
// Power-of-two divider giving a one-cycle enable pulse.
// Assumes tick_in is a one-cycle enable on ref_clk.
`default_nettype none
module lf_divider #(
  parameter int width = 15
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic run,
  input wire logic tick_in,
  input wire logic [3:0] log2_div,
  output logic tick_out
);
  logic [width-1:0] count;
  logic [width-1:0] next_count;
  logic [width-1:0] mask;

  // Division by up to 2^15 needs at least a 15-bit count
  if (width < 15 || width > 31)
  begin : g_bad_width
    $error("lf_divider width out of range");
  end

  // Count input ticks; emit when masked low bits are all ones
  always_comb
  begin
    mask = width'((32'h0000_0001 << log2_div) - 32'h0000_0001);
    next_count = count;
    if (!run)
      next_count = '0;
    else if (tick_in)
      next_count = ((count & mask) == mask) ? '0 : count + width'(1);
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      count <= '0;
    else
      count <= next_count;
  end

  assign tick_out = run && tick_in && ((count & mask) == mask);
endmodule
`default_nettype wire

/* core/lf_clock_bank.sv */
// APB register bank driving low-frequency gates and prescaled ticks.
// Assumes the A and B tree clocks arrive as one-cycle ticks on ref_clk.
`default_nettype none
module lf_clock_bank (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic lf_tree_a_clock,
  input wire logic lf_tree_b_clock,
  input wire logic pulse_counter_input_pin,
  output logic display_controller_tick,
  output logic low_energy_timer_tick,
  output logic real_time_counter_tick,
  output logic sensor_interface_tick,
  output logic low_energy_serial_port_tick,
  output logic pulse_counter_tick,
  output logic boost_update_tick,
  output logic boost_on,
  output logic [2:0] pin_select_a,
  output logic clock_out_second_pin_on,
  output logic clock_out_first_pin_on
);
  import lf_clock_pkg::*;

  // ------------------------------------------------------------
  // Bus side registers
  // ------------------------------------------------------------
  logic update_hold, next_update_hold;
  logic locked, next_locked;
  logic [15:0] bus_val [num_async];
  logic [15:0] next_bus_val [num_async];
  logic [15:0] xfer_val [num_async];
  logic [15:0] next_xfer_val [num_async];
  logic [num_async-1:0] pend, next_pend;
  logic [1:0] pcnt_ctrl, next_pcnt_ctrl;
  logic [6:0] disp_ctrl, next_disp_ctrl;
  logic [4:0] route, next_route;
  logic [31:0] next_prdata;
  logic wr, rd, lock_ok;
  // ------------------------------------------------------------
  // Handshake crossing and low-frequency side copies
  // ------------------------------------------------------------
  logic [num_async-1:0] req, next_req, ack, ack_s1, ack_s2, req_s1, req_s2;
  logic [15:0] lf_val [num_async];
  logic [num_async-1:0] busy;

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite; // Latched in setup, stands at the access edge
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign lock_ok = !locked;

  // Register writes, read mux and pending marks
  always_comb
  begin
    next_update_hold = update_hold;
    next_locked = locked;
    next_bus_val = bus_val;
    next_pend = pend;
    next_pcnt_ctrl = pcnt_ctrl;
    next_disp_ctrl = disp_ctrl;
    next_route = route;
    next_prdata = prdata;
    next_req = req;
    next_xfer_val = xfer_val;
    for (int i = 0; i < num_async; i++)
    begin
      // Launch a transfer only when idle and not held
      if (pend[i] && !update_hold && req[i] == ack_s2[i])
      begin
        next_req[i] = !req[i];
        next_pend[i] = 1'b0;
        next_xfer_val[i] = bus_val[i]; // Frozen copy while the toggle crosses
      end
    end
    if (wr)
    begin
      unique case (paddr)
        off_freeze: next_update_hold = pwdata[0];
        off_lock: next_locked = (pwdata[15:0] != unlock_key);
        off_lfa_gates:
          if (lock_ok)
          begin
            next_bus_val[0] = {12'h000, pwdata[3:0]};
            next_pend[0] = 1'b1;
          end
        off_lfa_presc:
          if (lock_ok)
          begin
            next_bus_val[1] = {2'b00, pwdata[13:4], 2'b00, pwdata[1:0]};
            next_pend[1] = 1'b1;
          end
        off_lfb_gates:
          if (lock_ok)
          begin
            next_bus_val[2] = {15'h0000, pwdata[0]};
            next_pend[2] = 1'b1;
          end
        off_lfb_presc:
          if (lock_ok)
          begin
            next_bus_val[3] = {14'h0000, pwdata[1:0]};
            next_pend[3] = 1'b1;
          end
        off_pcnt_ctrl: if (lock_ok) next_pcnt_ctrl = pwdata[1:0];
        off_disp_ctrl: next_disp_ctrl = pwdata[6:0];
        off_route: next_route = pwdata[4:0];
        default: ;
      endcase
    end
    if (rd)
    begin
      unique case (paddr)
        off_freeze: next_prdata = {31'h0, update_hold};
        off_lock: next_prdata = {31'h0, locked};
        off_sync_busy:
        begin
          next_prdata = 32'h0000_0000;
          next_prdata[busy_lfa_gates_bit] = busy[0];
          next_prdata[busy_lfa_presc_bit] = busy[1];
          next_prdata[busy_lfb_gates_bit] = busy[2];
          next_prdata[busy_lfb_presc_bit] = busy[3];
        end
        off_lfa_gates: next_prdata = {16'h0000, bus_val[0]};
        off_lfa_presc: next_prdata = {16'h0000, bus_val[1]};
        off_lfb_gates: next_prdata = {16'h0000, bus_val[2]};
        off_lfb_presc: next_prdata = {16'h0000, bus_val[3]};
        off_pcnt_ctrl: next_prdata = {30'h0, pcnt_ctrl};
        off_disp_ctrl: next_prdata = {25'h0, disp_ctrl};
        off_route: next_prdata = {27'h0, route};
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      update_hold <= 1'b0;
      locked <= 1'b0;
      bus_val <= '{default: 16'h0000};
      pend <= '0;
      pcnt_ctrl <= 2'b00;
      disp_ctrl <= {boost_div_reset, 4'h0};
      route <= 5'h00;
      prdata <= 32'h0000_0000;
      req <= '0;
      xfer_val <= '{default: 16'h0000};
    end
    else
    begin
      update_hold <= next_update_hold;
      locked <= next_locked;
      bus_val <= next_bus_val;
      pend <= next_pend;
      pcnt_ctrl <= next_pcnt_ctrl;
      disp_ctrl <= next_disp_ctrl;
      route <= next_route;
      prdata <= next_prdata;
      req <= next_req;
      xfer_val <= next_xfer_val;
    end
  end

  // Busy while a value waits or its toggle is not yet acknowledged
  assign busy = pend | (req ^ ack_s2);

  // Low-frequency side: sample request, capture data, return ack
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      req_s1 <= '0;
      req_s2 <= '0;
      ack <= '0;
      ack_s1 <= '0;
      ack_s2 <= '0;
      lf_val <= '{default: 16'h0000};
    end
    else
    begin
      req_s1 <= req;
      req_s2 <= req_s1;
      ack_s1 <= ack;
      ack_s2 <= ack_s1;
      for (int i = 0; i < num_async; i++)
      begin
        if (req_s2[i] != ack[i] && lf_tree_a_clock)
        begin
          lf_val[i] <= xfer_val[i];
          ack[i] <= req_s2[i];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Gates and dividers
  // ------------------------------------------------------------
  logic disp_pre_tick, disp_frame_tick, timer_tick, rtc_tick, sense_tick, uart_tick;
  logic [2:0] frame_count, next_frame_count;
  logic pcnt_src;

  lf_divider #(.width(15)) u_disp_pre (
    .ref_clk(ref_clk), .rst_b(rst_b), .run(lf_val[0][3]), .tick_in(lf_tree_a_clock),
    .log2_div(4'(lf_val[1][13:12]) + 4'(disp_presc_base)), .tick_out(disp_pre_tick));
  lf_divider #(.width(15)) u_timer (
    .ref_clk(ref_clk), .rst_b(rst_b), .run(lf_val[0][2]), .tick_in(lf_tree_a_clock),
    .log2_div(lf_val[1][11:8]), .tick_out(timer_tick));
  lf_divider #(.width(15)) u_rtc (
    .ref_clk(ref_clk), .rst_b(rst_b), .run(lf_val[0][1]), .tick_in(lf_tree_a_clock),
    .log2_div(lf_val[1][7:4]), .tick_out(rtc_tick));
  lf_divider #(.width(15)) u_sense (
    .ref_clk(ref_clk), .rst_b(rst_b), .run(lf_val[0][0]), .tick_in(lf_tree_a_clock),
    .log2_div({2'b00, lf_val[1][1:0]}), .tick_out(sense_tick));
  lf_divider #(.width(15)) u_uart (
    .ref_clk(ref_clk), .rst_b(rst_b), .run(lf_val[2][0]), .tick_in(lf_tree_b_clock),
    .log2_div({2'b00, lf_val[3][1:0]}), .tick_out(uart_tick));
  lf_divider #(.width(15)) u_boost (
    .ref_clk(ref_clk), .rst_b(rst_b), .run(1'b1), .tick_in(lf_tree_a_clock),
    .log2_div({1'b0, disp_ctrl[6:4]}), .tick_out(boost_update_tick));

  // Frame-rate divider by one plus the field
  always_comb
  begin
    next_frame_count = frame_count;
    disp_frame_tick = 1'b0;
    if (!lf_val[0][3])
      next_frame_count = 3'h0;
    else if (disp_pre_tick)
    begin
      if (frame_count >= disp_ctrl[2:0])
      begin
        next_frame_count = 3'h0;
        disp_frame_tick = 1'b1;
      end
      else
        next_frame_count = frame_count + 3'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      frame_count <= 3'h0;
    else
      frame_count <= next_frame_count;
  end

  assign pcnt_src = pcnt_ctrl[1] ? pulse_counter_input_pin : lf_tree_a_clock;
  assign pulse_counter_tick = pcnt_ctrl[0] && pcnt_src;
  assign display_controller_tick = disp_frame_tick;
  assign low_energy_timer_tick = timer_tick;
  assign real_time_counter_tick = rtc_tick;
  assign sensor_interface_tick = sense_tick;
  assign low_energy_serial_port_tick = uart_tick;
  assign boost_on = disp_ctrl[3];
  assign pin_select_a = route[4:2];
  assign clock_out_second_pin_on = route[1];
  assign clock_out_first_pin_on = route[0];

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_hold_blocks: assert property (@(posedge ref_clk) disable iff (!rst_b)
    update_hold && $stable(update_hold) |-> $stable(req))
    else $error("transfer launched while held");
  a_release_launch: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (!update_hold && pend[0] && req[0] == ack_s2[0]) |=> req[0] != $past(req[0]))
    else $error("pending value not launched");
  a_lock_ignore: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (locked && wr && paddr == off_lfa_gates) |=> $stable(bus_val[0]))
    else $error("locked register changed");
  a_unlock_key: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (wr && paddr == off_lock && pwdata[15:0] == unlock_key) |=> !locked)
    else $error("key did not unlock");
  a_busy_write: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (wr && lock_ok && paddr == off_lfb_presc) |=> busy[3])
    else $error("busy not raised after write");
  a_pcnt_gate: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !pcnt_ctrl[0] |-> !pulse_counter_tick)
    else $error("pulse counter clock leaks");
  a_gate_off: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !lf_val[2][0] |-> !low_energy_serial_port_tick)
    else $error("serial port tick while gated");
  a_cross_done: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (busy[0] && !pend[0] && req_s2[0] != ack[0] && lf_tree_a_clock)
    |-> ##[1:3] (!busy[0] || pend[0]))
    else $error("crossing did not complete");
  c_write_gate: cover property (@(posedge ref_clk) wr && paddr == off_lfa_gates);
  c_held_release: cover property (@(posedge ref_clk) $fell(update_hold) && |pend);
  c_display_tick: cover property (@(posedge ref_clk) display_controller_tick);
  c_locked_write: cover property (@(posedge ref_clk) locked && wr);
endmodule
`default_nettype wire

/* tb/lf_peripheral_model.sv */
// Model of the low-frequency peripherals beside the clock bank.
// Assumes one ref_clk; it makes tree ticks and a pin pulse, and counts returned ticks.
`default_nettype none
module lf_peripheral_model (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clr,
  input wire logic [6:0] ticks,
  output logic tree_a,
  output logic tree_b,
  output logic pin,
  output logic [6:0][15:0] cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] phase;
  // Tree ticks every four cycles out of phase, pin pulse every eight
  assign tree_a = (phase[1:0] == 2'h0);
  assign tree_b = (phase[1:0] == 2'h2);
  assign pin = (phase == 3'h5);
  // Free-running phase and one tick counter per peripheral
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      phase <= 3'h0;
      cnt <= '0;
    end
    else
    begin
      phase <= phase + 3'h1;
      for (int i = 0; i < 7; i++)
        cnt[i] <= clr ? 16'h0000 : cnt[i] + 16'(ticks[i]);
    end
  end
endmodule
`default_nettype wire

/* tb/lf_clock_bank_tb_top.sv */
// Self-checking bench for the low-frequency clock bank.
// Assumes the peripheral model makes tree ticks and counts output ticks.
`default_nettype none
module lf_clock_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import lf_clock_pkg::*;
  logic ref_clk;
  logic rst_b;
  logic psel, penable, pwrite, clr;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] rd;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, tree_a, tree_b, pin, boost_on, pin_hi, pin_lo;
  wire logic [2:0] pin_select_a;
  wire logic [6:0] ticks;
  wire logic [6:0][15:0] cnt;
  int fail_count;
  int checks_done;
  int cycles;
  // ----------------------------------------
  // Design and peripheral model
  // ----------------------------------------
  lf_clock_bank DUT (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lf_tree_a_clock(tree_a), .lf_tree_b_clock(tree_b),
    .pulse_counter_input_pin(pin), .display_controller_tick(ticks[6]),
    .low_energy_timer_tick(ticks[5]), .real_time_counter_tick(ticks[4]),
    .sensor_interface_tick(ticks[3]), .low_energy_serial_port_tick(ticks[2]),
    .pulse_counter_tick(ticks[1]), .boost_update_tick(ticks[0]), .boost_on(boost_on),
    .pin_select_a(pin_select_a), .clock_out_second_pin_on(pin_hi),
    .clock_out_first_pin_on(pin_lo));
  lf_peripheral_model periph (.ref_clk(ref_clk), .rst_b(rst_b), .clr(clr),
    .ticks(ticks), .tree_a(tree_a), .tree_b(tree_b), .pin(pin), .cnt(cnt));
  // ----------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------
  initial
  begin
    ref_clk = 1'h0;
    forever #4 ref_clk = ~ref_clk;
  end
  // Cut a hang short well past the expected run length
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      fail_count++;
      final_report();
    end
  end
  task automatic final_report();
    if (fail_count == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Compare a tick count over one window against the expected count
  task automatic cc(input int i, input int e);
    chk({16'h0000, cnt[i]}, 32'(e));
  endtask
  // One APB transfer; read data is taken at the edge that completes it
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    do
    begin
      @(posedge ref_clk);
    end
    while (pready !== 1'h1);
    rd = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
    @(negedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rdr(input logic [7:0] a);
    apb(1'h0, a, 32'h0000_0000);
  endtask
  // Poll the busy flags until every async register has crossed
  task automatic sync_wait();
    int n;
    n = 0;
    do
    begin
      rdr(off_sync_busy);
      n++;
    end
    while ((rd & 32'h0000_0055) != 0 && n < 40);
    chk(rd & 32'h0000_0055, 32'h0000_0000);
  endtask
  // Settle, clear counters, then count for 256 cycles (64 tree ticks)
  task automatic window();
    repeat (16) @(posedge ref_clk);
    clr <= 1'h1;
    @(posedge ref_clk);
    clr <= 1'h0;
    repeat (256) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [7:0] a [9] = '{off_lfa_gates, off_lfb_gates, off_lfa_presc, off_lfb_presc,
      off_pcnt_ctrl, off_disp_ctrl, off_route, off_freeze, off_sync_busy};
    for (int i = 0; i < 9; i++)
    begin
      rdr(a[i]);
      chk(rd, (a[i] == off_disp_ctrl) ? 32'h0000_0020 : 32'h0000_0000);
    end
  endtask
  task automatic t_lock();
    wr(off_lock, 32'h0000_0000);
    rdr(off_lock);
    chk(rd, 32'h0000_0001);
    wr(off_lfa_gates, 32'h0000_000f);
    chk({31'h0000_0000, pslverr}, 32'h0000_0000);
    rdr(off_lfa_gates);
    chk(rd, 32'h0000_0000);
    wr(off_lock, {16'h0000, unlock_key});
    rdr(off_lock);
    chk(rd, 32'h0000_0000);
    wr(8'h00, 32'hffff_ffff);
    rdr(8'h00);
    chk(rd, 32'h0000_0000);
  endtask
  task automatic t_ticks();
    wr(off_disp_ctrl, 32'h0000_0021); // Frame field set before the gate opens
    wr(off_lfa_presc, 32'h0000_0231);
    wr(off_lfb_presc, 32'h0000_0003);
    wr(off_pcnt_ctrl, 32'h0000_0001);
    wr(off_lfb_gates, 32'h0000_0001);
    wr(off_lfa_gates, 32'h0000_000f);
    sync_wait();
    rdr(off_lfa_presc);
    chk(rd, 32'h0000_0231);
    window();
    cc(6, 2);
    cc(5, 16);
    cc(4, 8);
    cc(3, 32);
    cc(2, 8);
    cc(1, 64);
    cc(0, 16);
  endtask
  task automatic t_pin();
    wr(off_pcnt_ctrl, 32'h0000_0003);
    window();
    cc(1, 32);
    wr(off_pcnt_ctrl, 32'h0000_0002);
    window();
    cc(1, 0);
  endtask
  task automatic t_outputs();
    wr(off_route, 32'h0000_001f);
    chk({27'h000_0000, pin_select_a, pin_hi, pin_lo}, 32'h0000_001f);
    wr(off_route, 32'h0000_000a);
    chk({27'h000_0000, pin_select_a, pin_hi, pin_lo}, 32'h0000_000a);
    wr(off_disp_ctrl, 32'h0000_0059);
    chk({31'h0000_0000, boost_on}, 32'h0000_0001);
    window();
    cc(0, 2);
    cc(6, 2);
    wr(off_disp_ctrl, 32'h0000_0051);
    chk({31'h0000_0000, boost_on}, 32'h0000_0000);
  endtask
  task automatic t_freeze();
    wr(off_freeze, 32'h0000_0001);
    wr(off_lfa_gates, 32'h0000_0000);
    wr(off_lfb_gates, 32'h0000_0000);
    repeat (40) @(posedge ref_clk);
    rdr(off_sync_busy);
    chk(rd & 32'h0000_0055, 32'h0000_0011);
    window();
    cc(5, 16);
    cc(2, 8);
    wr(off_freeze, 32'h0000_0000);
    sync_wait();
    window();
    cc(5, 0);
    cc(6, 0);
    cc(2, 0);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    rst_b = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    clr = 1'h0;
    fail_count = 0;
    checks_done = 0;
    cycles = 0;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'h1;
    t_reset();
    t_lock();
    t_ticks();
    t_pin();
    t_outputs();
    t_freeze();
    final_report();
  end
endmodule
`default_nettype wire
